// ---- ir_mux_pkg.sv ----
package ir_mux_pkg;

    // =========================================================================
    // Pin positions within the four shared low data lines.
    localparam int unsigned PIN_COUNT = 4;
    localparam int unsigned PIN_TX = 0;
    localparam int unsigned PIN_FAST = 1;
    localparam int unsigned PIN_RX = 2;
    localparam int unsigned PIN_SPEED = 3;

    // =========================================================================
    // Reset values and transceiver direction codes.
    localparam logic STRAP_RESET = 1'b0;
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic DIR_TO_SLOT = 1'b1;
    localparam logic DIR_TO_BUS = 1'b0;
    localparam logic IR_IDLE = 1'b1;

    // =========================================================================
    // Pin function currently applied to the shared pins.
    typedef enum logic [1:0] {
        FUNC_SLOT = 2'b00,
        FUNC_GPIO = 2'b01,
        FUNC_IR = 2'b11
    } pin_func_type;

    // Two-signal view of a group of two-way pins.
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } pin_drive_type;

    // Infrared controller side.
    typedef struct packed {
        logic tx;
        logic mode;
        logic speed;
    } ir_ctrl_type;

endpackage : ir_mux_pkg

// ---- isa_low_data_ir_gpio_mux.sv ----
`timescale 1ns/1ps
// Behaviour
// - strap low: pins are slot data lines
// - strap high: alternate functions, transceiver carries data
// - config bit clear: all pins general I/O
// - config bit set: pins infrared, line 3 unused with first module
// - line 2 is infrared receive input
// - line 0 is infrared transmit output
// - first module: line 1 fast receive input
// - second module: line 1 drives mode output
// - second module: line 3 drives speed control
// - drive transceiver direction when pins taken
module isa_low_data_ir_gpio_mux
    import ir_mux_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Strap and configuration.
    input wire logic strap_tc_in,
    input wire logic ir_enable_in,
    input wire logic ir_module_second_in,
    // Shared pins.
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_out,
    // Internal ISA low-nibble data path.
    input wire logic [3:0] slot_data_in,
    input wire logic slot_data_drive_in,
    output logic [3:0] slot_data_out,
    // General-purpose I/O side.
    input wire logic [3:0] gpio_data_in,
    input wire logic [3:0] gpio_oe_in,
    output logic [3:0] gpio_data_out,
    // Infrared controller side.
    input wire ir_ctrl_type ir_ctrl_in,
    output logic ir_serial_receive_out,
    output logic ir_fast_receive_out,
    // External transceiver steering.
    output logic transceiver_direction_out,
    output logic [1:0] pin_func_out
);

    // =========================================================================
    // Pin synchronisers and strap capture.
    logic [3:0] pin_meta_q, pin_meta_d;
    logic [3:0] pin_sync_q, pin_sync_d;
    logic strap_meta_q, strap_meta_d;
    logic strap_sync_q, strap_sync_d;
    logic strap_q, strap_d;
    logic in_reset_q, in_reset_d;

    always_comb begin
        pin_meta_d = pin_in;
        pin_sync_d = pin_meta_q;
        strap_meta_d = strap_tc_in;
        strap_sync_d = strap_meta_q;
        in_reset_d = 1'b0;
        strap_d = strap_q;
        // The strap is caught on the first edge after release, from the
        // synchronised level, so later strap motion cannot move the pins.
        if (in_reset_q) begin
            strap_d = strap_sync_q;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        // The strap synchroniser runs through reset so its level is settled at
        // release; clearing it in reset would always capture a low strap.
        strap_meta_q <= strap_meta_d;
        strap_sync_q <= strap_sync_d;
        if (!nrst_in) begin
            pin_meta_q <= NIBBLE_RESET;
            pin_sync_q <= NIBBLE_RESET;
            strap_q <= STRAP_RESET;
            in_reset_q <= 1'b1;
        end else begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
            strap_q <= strap_d;
            in_reset_q <= in_reset_d;
        end
    end

    // =========================================================================
    // Function selection and pin drive.
    pin_func_type func_q, func_d;
    pin_drive_type drive_q, drive_d;
    logic [3:0] slot_rd_q, slot_rd_d;
    logic [3:0] gpio_rd_q, gpio_rd_d;
    logic rx_q, rx_d;
    logic fast_q, fast_d;
    logic dir_q, dir_d;

    always_comb begin
        func_d = FUNC_SLOT;
        if (strap_q) begin
            func_d = ir_enable_in ? FUNC_IR : FUNC_GPIO;
        end
        drive_d.out = NIBBLE_RESET;
        drive_d.oe = NIBBLE_RESET;
        slot_rd_d = NIBBLE_RESET;
        gpio_rd_d = NIBBLE_RESET;
        rx_d = IR_IDLE;
        fast_d = IR_IDLE;
        dir_d = DIR_TO_SLOT;
        case (func_q)
            FUNC_SLOT: begin
                drive_d.out = slot_data_in;
                drive_d.oe = {PIN_COUNT{slot_data_drive_in}};
                slot_rd_d = pin_sync_q;
            end
            FUNC_GPIO: begin
                drive_d.out = gpio_data_in;
                drive_d.oe = gpio_oe_in;
                gpio_rd_d = pin_sync_q;
            end
            FUNC_IR: begin
                drive_d.out[PIN_TX] = ir_ctrl_in.tx;
                drive_d.oe[PIN_TX] = 1'b1;
                rx_d = pin_sync_q[PIN_RX];
                if (ir_module_second_in) begin
                    drive_d.out[PIN_FAST] = ir_ctrl_in.mode;
                    drive_d.oe[PIN_FAST] = 1'b1;
                    drive_d.out[PIN_SPEED] = ir_ctrl_in.speed;
                    drive_d.oe[PIN_SPEED] = 1'b1;
                end else begin
                    fast_d = pin_sync_q[PIN_FAST];
                end
            end
            default: begin
                drive_d.out = NIBBLE_RESET;
            end
        endcase
        // With the pins taken, slot data goes through the transceiver; it
        // points at the slot when the core drives, toward the bus otherwise.
        if (func_q != FUNC_SLOT) begin
            dir_d = slot_data_drive_in ? DIR_TO_SLOT : DIR_TO_BUS;
            slot_rd_d = NIBBLE_RESET;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            func_q <= FUNC_SLOT;
            drive_q <= '0;
            slot_rd_q <= NIBBLE_RESET;
            gpio_rd_q <= NIBBLE_RESET;
            rx_q <= IR_IDLE;
            fast_q <= IR_IDLE;
            dir_q <= DIR_TO_SLOT;
        end else begin
            func_q <= func_d;
            drive_q <= drive_d;
            slot_rd_q <= slot_rd_d;
            gpio_rd_q <= gpio_rd_d;
            rx_q <= rx_d;
            fast_q <= fast_d;
            dir_q <= dir_d;
        end
    end

    assign pin_out = drive_q.out;
    assign pin_oe_out = drive_q.oe;
    assign slot_data_out = slot_rd_q;
    assign gpio_data_out = gpio_rd_q;
    assign ir_serial_receive_out = rx_q;
    assign ir_fast_receive_out = fast_q;
    assign transceiver_direction_out = dir_q;
    assign pin_func_out = func_q;

    // =========================================================================
    // Checks.
    strap_low_slot_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        ##1 (!strap_q && $stable(strap_q)) |=> func_q == FUNC_SLOT)
        else $error("strap low but pins not slot data");
    gpio_mode_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (strap_q && !ir_enable_in) |=> func_q == FUNC_GPIO)
        else $error("gpio mode not selected");
    ir_mode_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (strap_q && ir_enable_in) |=> func_q == FUNC_IR)
        else $error("infrared mode not selected");
    ir_rx_path_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_IR) |=> rx_q == $past(pin_sync_q[PIN_RX]) && !drive_q.oe[PIN_RX])
        else $error("receive pin not routed");
    ir_tx_path_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_IR) |=> drive_q.oe[PIN_TX] && drive_q.out[PIN_TX] == $past(ir_ctrl_in.tx))
        else $error("transmit pin not driven");
    fast_rx_path_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_IR && !ir_module_second_in) |=>
        !drive_q.oe[PIN_FAST] && fast_q == $past(pin_sync_q[PIN_FAST]))
        else $error("fast receive pin driven");
    mode_out_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_IR && ir_module_second_in) |=>
        drive_q.oe[PIN_FAST] && drive_q.out[PIN_FAST] == $past(ir_ctrl_in.mode))
        else $error("mode pin not driven");
    speed_out_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_IR && ir_module_second_in) |=>
        drive_q.oe[PIN_SPEED] && drive_q.out[PIN_SPEED] == $past(ir_ctrl_in.speed))
        else $error("speed pin not driven");
    xcvr_dir_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q != FUNC_SLOT && !slot_data_drive_in) |=> dir_q == DIR_TO_BUS)
        else $error("transceiver direction wrong");
    strap_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        !in_reset_q |=> $stable(strap_q))
        else $error("strap changed outside reset");
    strap_capture_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        in_reset_q |=> strap_q == $past(strap_sync_q))
        else $error("strap not captured at reset release");
    slot_drive_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_SLOT) |=> dir_q == DIR_TO_SLOT && drive_q.out == $past(slot_data_in))
        else $error("slot data not driven");
    slot_read_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_SLOT) |=> slot_rd_q == $past(pin_sync_q))
        else $error("slot data not read");
    alt_slot_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q != FUNC_SLOT) |=> slot_rd_q == NIBBLE_RESET)
        else $error("slot read active while pins taken");
    gpio_pins_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_GPIO) |=> drive_q.oe == $past(gpio_oe_in) && gpio_rd_q == $past(pin_sync_q))
        else $error("gpio pins not routed");
    ir_gpio_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q == FUNC_IR) |=> gpio_rd_q == NIBBLE_RESET)
        else $error("gpio read active in infrared mode");
    rx_idle_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q != FUNC_IR) |=> rx_q == IR_IDLE && fast_q == IR_IDLE)
        else $error("infrared receive not idle");
    xcvr_drive_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        (func_q != FUNC_SLOT && slot_data_drive_in) |=> dir_q == DIR_TO_SLOT)
        else $error("transceiver not pointed at slot");

endmodule : isa_low_data_ir_gpio_mux

// ---- far_side_model.sv ----
`timescale 1ns/1ps
// =============================================================================
// Far side of the shared pins: slot device or infrared module.
module far_side_model (
    // Device side.
    input wire logic [3:0] drv_in,
    input wire logic [3:0] oe_in,
    // Far-side levels, used wherever the device does not drive.
    input wire logic [3:0] ext_in,
    // Resolved wire levels.
    output logic [3:0] pin_out
);
    // The far side drives only the pins that the device has released.
    assign pin_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule : far_side_model

// ---- tb_isa_low_data_ir_gpio_mux.sv ----
`timescale 1ns/1ps
module tb_isa_low_data_ir_gpio_mux;
    import ir_mux_pkg::*;
    // =========================================================================
    // Stimulus and observation.
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic strap, cap, en, sec, drv, rx_o, fast_o, dir_o;
    logic [3:0] sd, gd, goe, ext, pin_lvl, pin_o, pin_oe, slot_o, gpio_o;
    logic [1:0] func_o;
    logic [7:0] lfsr_q = 8'h3a;
    logic [20:0] seen_v, exp_v;
    ir_ctrl_type ctrl;
    int n_fail = 0;
    int cmp_count = 0;
    logic [20:0] notes[$];
    event chk;

    always #4 clk_sys_in = ~clk_sys_in;

    isa_low_data_ir_gpio_mux DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .strap_tc_in(strap),
        .ir_enable_in(en), .ir_module_second_in(sec), .pin_in(pin_lvl), .pin_out(pin_o), .pin_oe_out(pin_oe),
        .slot_data_in(sd), .slot_data_drive_in(drv), .slot_data_out(slot_o), .gpio_data_in(gd),
        .gpio_oe_in(goe), .gpio_data_out(gpio_o), .ir_ctrl_in(ctrl), .ir_serial_receive_out(rx_o),
        .ir_fast_receive_out(fast_o), .transceiver_direction_out(dir_o), .pin_func_out(func_o));

    far_side_model FAR (.drv_in(pin_o), .oe_in(pin_oe), .ext_in(ext), .pin_out(pin_lvl));

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next

    // =========================================================================
    // Drives one setting with random data and notes the expected outputs.
    task automatic step(input logic s_en, input logic s_sec, input logic s_drv);
        logic [3:0] oe, o, lvl;
        logic [1:0] f;
        @(posedge clk_sys_in);
        #1;
        lfsr_q = lfsr_next(lfsr_q);
        {gd, sd} = lfsr_q;
        lfsr_q = lfsr_next(lfsr_q);
        {ext, goe} = lfsr_q;
        lfsr_q = lfsr_next(lfsr_q);
        ctrl = lfsr_q[2:0];
        en = s_en;
        sec = s_sec;
        drv = s_drv;
        f = !cap ? FUNC_SLOT : (en ? FUNC_IR : FUNC_GPIO);
        case (f)
            FUNC_SLOT: begin
                oe = {4{drv}};
                o = sd;
            end
            FUNC_GPIO: begin
                oe = goe;
                o = gd;
            end
            default: begin
                oe = {sec, 1'b0, sec, 1'b1};
                o = {ctrl.speed, 1'b0, ctrl.mode, ctrl.tx};
            end
        endcase
        lvl = (oe & o) | (~oe & ext);
        repeat (5) @(posedge clk_sys_in);
        #1;
        notes.push_back({f, (f == FUNC_SLOT) ? 1'b1 : drv, (f == FUNC_IR) ? lvl[2] : 1'b1,
            (f == FUNC_IR && !sec) ? lvl[1] : 1'b1, (f == FUNC_SLOT) ? lvl : 4'h0,
            (f == FUNC_GPIO) ? lvl : 4'h0, oe, o & oe});
        ->chk;
    endtask : step

    // Second process: takes the oldest note whenever a result is due.
    always @(chk) begin
        exp_v = notes.pop_front();
        seen_v = {func_o, dir_o, rx_o, fast_o, slot_o, gpio_o, pin_oe, pin_o & pin_oe};
        cmp_count++;
        if (seen_v !== exp_v) begin
            n_fail++;
            $display("[FAIL] outputs expected %h seen %h", exp_v, seen_v);
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // =========================================================================
    // Main sequence and watchdog.
    initial begin
        {strap, cap, en, sec, drv, sd, gd, goe, ext} = '0;
        ctrl = '0;
        repeat (2) @(posedge clk_sys_in);
        #1 nrst_in = 1'b1;
        for (int i = 0; i < 4; i++) step(i[1], i[0], i[0]);
        $display("slot mode test done");
        nrst_in = 1'b0;
        strap = 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1 nrst_in = 1'b1;
        cap = 1'b1;
        strap = 1'b0;
        for (int i = 0; i < 16; i++) step(i[2], i[1], i[0]);
        $display("alternate function test done");
        @(posedge clk_sys_in);
        summarize();
    end

    initial begin
        #20000;
        n_fail++;
        summarize();
    end
endmodule : tb_isa_low_data_ir_gpio_mux
